// ---- verilog/swuart_map.vh ----
`ifndef SWUART_MAP_VH
`define SWUART_MAP_VH

// ==========================================================
// Frame contents
// Node address this device answers to
`define NODE_ADDR 8'h00
// Address byte placed in every reply toward the host
`define REPLY_ADDR 8'hff
// Sync nibble 1,0,1,0 sent LSB first, reserved bits zero
`define SYNC_TX_BYTE 8'h05
// Sync nibble already shifted into the top of the receive byte
`define SYNC_RX_PRELOAD 8'h50
// CRC polynomial x^8+x^2+x+1 without the top term
`define CRC_POLY 8'h07
// CRC start value
`define CRC_INIT 8'h00

// ==========================================================
// Timing, in core clock cycles
// Shortest low pulse on an idle line that is not a glitch
`define GLITCH_CYC 18'h00010
// Shortest accepted bit period (core clock divided by 16)
`define MIN_BIT_CYC 16'h0010
// Saturation value of the sync measurement counter
`define MEAS_MAX 18'h3ffff

// ==========================================================
// Timing, in bit times
// Start-to-start gap that abandons a reception
`define GAP_BITS 7'h3f
// Idle time needed after an error or glitch
`define RECOVER_BITS 7'h0c
// Release of the driver after the last stop bit
`define RELEASE_BITS 7'h04
// Frame bits of one byte after the start bit (8 data, 1 stop)
`define TX_LAST_BIT 4'h9

`endif

// ---- verilog/swuart_tx.v ----
`timescale 1ns/1ns
`default_nettype none
`include "swuart_map.vh"

module swuart_tx (
    input wire i_clk, // Core clock
    input wire i_rst_n, // Synchronous reset, active low
    input wire [15:0] i_bit_len, // Bit period in cycles
    input wire i_go, // One-cycle request to send i_byte
    input wire [7:0] i_byte, // Byte to send
    output wire o_ready, // High while no byte is being sent
    output reg o_txd_q // Serial line level
);

reg busy_q;
reg [9:0] sh_q;
reg [3:0] n_q;
reg [15:0] tmr_q;

assign o_ready = ~busy_q;

// ==========================================================
// Byte serialiser
// Start bit low, eight data bits LSB first, stop bit high
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        busy_q <= 1'b0;
        sh_q <= 10'h3ff;
        n_q <= 4'h0;
        tmr_q <= 16'h0000;
        o_txd_q <= 1'b1;
    end else if (!busy_q) begin
        if (i_go) begin
            sh_q <= {1'b1, i_byte, 1'b0}; // [R7] [R4]
            o_txd_q <= 1'b0;
            n_q <= 4'h0;
            tmr_q <= i_bit_len - 16'h0001;
            busy_q <= 1'b1;
        end
    end else if (tmr_q != 16'h0000) begin
        tmr_q <= tmr_q - 16'h0001;
    end else if (n_q == `TX_LAST_BIT) begin
        // Stop bit has stood a full bit time
        busy_q <= 1'b0;
        o_txd_q <= 1'b1;
    end else begin
        sh_q <= {1'b1, sh_q[9:1]};
        o_txd_q <= sh_q[1];
        n_q <= n_q + 4'h1;
        tmr_q <= i_bit_len - 16'h0001;
    end
end

endmodule
`default_nettype wire

// ---- verilog/swuart_slave.v ----
// What this block does
// [R1] Datagrams open with sync nibble 1,0,1,0
// [R2] Write datagram: eight bytes, ends with CRC
// [R3] Byte three: register address, bit7 write flag
// [R4] Bits LSB first, data word MSB first
// [R5] Reserved bits ignored but included in CRC
// [R6] Node address fixed at zero
// [R7] Start bit low, stop bit high
// [R8] Bit period from start to bit3 edge
// [R9] Baud divider remeasured every datagram
// [R10] Accept bit periods of sixteen cycles upward
// [R11] Abandon after 63 bit times between starts
// [R12] Host idles twelve bits after a reset
// [R13] Short idle pulse is glitch, then recover
// [R14] CRC or framing error handled like glitch
// [R15] Host avoids abrupt large baud drops
// [R16] Count accepted writes, eight bit wrapping
// [R17] Reads leave the write counter alone
// [R18] Host keeps line high when idle
// [R19] Pin power-down meaning gated by disable bit
// [R20] CRC8 x^8+x^2+x+1, zero start, LSB first
// [R21] Read request: four bytes, write flag clear
// [R22] Reply after eight-bit-time multiples of delay
// [R23] Reply to 0xFF, release four bits later
// [R24] Only complete, checked, addressed datagrams act
`timescale 1ns/1ns
`default_nettype none
`include "swuart_map.vh"

module swuart_slave (
    input wire I_CLK, // Core clock, 100 MHz
    input wire I_RST_N, // Synchronous reset, active low
    input wire I_DATA_PIN, // Single-wire data pin, input side
    output wire O_DATA_PIN, // Single-wire data pin, output side
    output wire O_DATA_OE, // High while this device drives the pin
    input wire I_PDN_DISABLE, // Power-down pin disable from global config
    input wire [3:0] I_REPLY_DELAY, // Reply delay setting, eight-bit units
    input wire [31:0] I_RD_DATA, // Register contents at O_RD_ADDR
    output reg O_WR_STB_Q, // One-cycle register write strobe
    output reg [6:0] O_WR_ADDR_Q, // Register address of the write
    output reg [31:0] O_WR_DATA_Q, // Data of the write
    output reg O_RD_STB_Q, // One-cycle register read strobe
    output reg [6:0] O_RD_ADDR_Q, // Register address of the read
    output reg [7:0] O_WR_COUNT_Q, // Accepted write datagram counter
    output reg O_PDN_REQ_Q // Pin asks for standstill power down
);

// ==========================================================
// States
localparam ST_IDLE = 3'h0;
localparam ST_MEAS = 3'h1;
localparam ST_RXBIT = 3'h2;
localparam ST_WSTART = 3'h3;
localparam ST_RECOV = 3'h4;
localparam ST_RDLY = 3'h5;
localparam ST_TXB = 3'h6;
localparam ST_RELS = 3'h7;

reg [2:0] st_q;
reg p1_q, p2_q, p3_q, lvl_q, lvl_prev_q;
reg [17:0] meas_q;
reg falls_q;
reg [15:0] bit_q, good_q;
reg [16:0] tmr_q;
reg [3:0] idx_q;
reg [3:0] bytes_q;
reg [7:0] sh_q, node_q, reg_q, crc_q;
reg [31:0] data_q;
reg [6:0] bits_q;
reg [55:0] rep_q;
reg tx_go_q;
reg [7:0] tx_byte_q;
wire tx_ready;
wire tx_line;

// ==========================================================
// CRC helper, one byte fed LSB first
function [7:0] crc8_byte;
    input [7:0] c;
    input [7:0] b;
    integer i;
    reg [7:0] r;
    begin
        r = c;
        for (i = 0; i < 8; i = i + 1) begin
            if (r[7] ^ b[i]) begin
                r = {r[6:0], 1'b0} ^ `CRC_POLY; // [R20]
            end else begin
                r = {r[6:0], 1'b0};
            end
        end
        crc8_byte = r;
    end
endfunction

// ==========================================================
// Pin synchroniser and filter
// The level moves only once the second and third stages agree
always @(posedge I_CLK) begin
    if (!I_RST_N) begin
        p1_q <= 1'b1;
        p2_q <= 1'b1;
        p3_q <= 1'b1;
        lvl_q <= 1'b1;
        lvl_prev_q <= 1'b1;
    end else begin
        p1_q <= I_DATA_PIN;
        p2_q <= p1_q;
        p3_q <= p2_q;
        if (p2_q == p3_q) begin
            lvl_q <= p2_q;
        end
        lvl_prev_q <= lvl_q;
    end
end

wire fall = lvl_prev_q & ~lvl_q;
wire rise = ~lvl_prev_q & lvl_q;
wire tick = (tmr_q == 17'h00000);

// Timeouts run on the period of the last good datagram, if any
wire [15:0] tmo_bit = (good_q != 16'h0000) ? good_q : bit_q; // [R11]
wire [16:0] bit_rl = {1'b0, bit_q} - 17'h00001;
wire [16:0] tmo_rl = {1'b0, tmo_bit} - 17'h00001;
wire [16:0] half_rl = {1'b0, bit_q} + {2'b00, bit_q[15:1]} - 17'h00001;
wire [15:0] meas_bit = meas_q[17:2];
wire [16:0] meas_half = {1'b0, meas_bit} + {2'b00, meas_bit[15:1]} - 17'h00001;
wire [7:0] rx_byte = sh_q;
wire [3:0] dly_units = (I_REPLY_DELAY == 4'h0) ? 4'h1 : I_REPLY_DELAY;
wire [6:0] dly_bits = {dly_units, 3'b000}; // [R22]
wire is_read_end = (bytes_q == 4'h3) & ~reg_q[7]; // [R3] [R21]
wire is_write_end = (bytes_q == 4'h7); // [R2]

// ==========================================================
// Reception, reply and recovery sequencer
always @(posedge I_CLK) begin
    if (!I_RST_N) begin
        st_q <= ST_IDLE;
        meas_q <= 18'h00000;
        falls_q <= 1'b0;
        bit_q <= `MIN_BIT_CYC;
        good_q <= 16'h0000;
        tmr_q <= 17'h00000;
        idx_q <= 4'h0;
        bytes_q <= 4'h0;
        sh_q <= 8'h00;
        node_q <= 8'h00;
        reg_q <= 8'h00;
        crc_q <= `CRC_INIT;
        data_q <= 32'h00000000;
        bits_q <= 7'h00;
        rep_q <= 56'h00000000000000;
        tx_go_q <= 1'b0;
        tx_byte_q <= 8'h00;
        O_WR_STB_Q <= 1'b0;
        O_WR_ADDR_Q <= 7'h00;
        O_WR_DATA_Q <= 32'h00000000;
        O_RD_STB_Q <= 1'b0;
        O_RD_ADDR_Q <= 7'h00;
        O_WR_COUNT_Q <= 8'h00;
    end else begin
        O_WR_STB_Q <= 1'b0;
        O_RD_STB_Q <= 1'b0;
        tx_go_q <= 1'b0;
        if (!tick) begin
            tmr_q <= tmr_q - 17'h00001;
        end
        case (st_q)
            ST_IDLE: begin
                // Every datagram restarts the baud measurement
                if (fall) begin
                    // The start edge cycle is itself the first counted cycle
                    meas_q <= 18'h00001;
                    falls_q <= 1'b0;
                    st_q <= ST_MEAS; // [R9]
                end
            end
            ST_MEAS: begin
                if (meas_q != `MEAS_MAX) begin
                    meas_q <= meas_q + 18'h00001;
                end
                if (!falls_q && rise && meas_q < `GLITCH_CYC) begin
                    bits_q <= 7'h00;
                    tmr_q <= tmo_rl;
                    st_q <= ST_RECOV; // [R13]
                end else if (meas_q == `MEAS_MAX) begin
                    bits_q <= 7'h00;
                    tmr_q <= tmo_rl;
                    st_q <= ST_RECOV; // [R10]
                end else if (fall && !falls_q) begin
                    // Edge from sync bit 0 to bit 1, not yet the end
                    falls_q <= 1'b1;
                end else if (fall) begin
                    // Edge from bit 2 to bit 3 closes four bit times
                    if (meas_bit < `MIN_BIT_CYC) begin
                        bits_q <= 7'h00;
                        tmr_q <= tmo_rl;
                        st_q <= ST_RECOV; // [R10]
                    end else begin
                        bit_q <= meas_bit; // [R8]
                        tmr_q <= meas_half;
                        idx_q <= 4'h4;
                        sh_q <= `SYNC_RX_PRELOAD; // [R1]
                        bytes_q <= 4'h0;
                        crc_q <= `CRC_INIT;
                        bits_q <= 7'h00;
                        st_q <= ST_RXBIT;
                    end
                end
            end
            ST_RXBIT: begin
                if (tick) begin
                    bits_q <= bits_q + 7'h01;
                    tmr_q <= bit_rl;
                    if (idx_q != 4'h8) begin
                        sh_q <= {lvl_q, sh_q[7:1]}; // [R4]
                        idx_q <= idx_q + 4'h1;
                    end else if (!lvl_q) begin
                        // Missing stop bit is a framing error
                        bits_q <= 7'h00;
                        tmr_q <= tmo_rl;
                        st_q <= ST_RECOV; // [R7] [R14]
                    end else if (is_read_end || is_write_end) begin
                        if (rx_byte != crc_q) begin
                            bits_q <= 7'h00;
                            tmr_q <= tmo_rl;
                            st_q <= ST_RECOV; // [R14] [R20]
                        end else if (node_q != `NODE_ADDR) begin
                            st_q <= ST_IDLE; // [R6] [R24]
                        end else if (is_write_end) begin
                            O_WR_STB_Q <= 1'b1; // [R24]
                            O_WR_ADDR_Q <= reg_q[6:0];
                            O_WR_DATA_Q <= data_q;
                            O_WR_COUNT_Q <= O_WR_COUNT_Q + 8'h01; // [R16]
                            good_q <= bit_q;
                            st_q <= ST_IDLE;
                        end else begin
                            // Read: counter untouched, reply at same baud
                            O_RD_STB_Q <= 1'b1; // [R17]
                            O_RD_ADDR_Q <= reg_q[6:0];
                            good_q <= bit_q;
                            bits_q <= 7'h00;
                            st_q <= ST_RDLY;
                        end
                    end else begin
                        // Reserved bits of byte 0 only feed the CRC
                        crc_q <= crc8_byte(crc_q, rx_byte); // [R5] [R20]
                        if (bytes_q == 4'h1) begin
                            node_q <= rx_byte;
                        end
                        if (bytes_q == 4'h2) begin
                            reg_q <= rx_byte;
                        end
                        if (bytes_q > 4'h2) begin
                            data_q <= {data_q[23:0], rx_byte}; // [R4]
                        end
                        bytes_q <= bytes_q + 4'h1;
                        tmr_q <= tmo_rl;
                        st_q <= ST_WSTART;
                    end
                end
            end
            ST_WSTART: begin
                if (fall) begin
                    tmr_q <= half_rl;
                    idx_q <= 4'h0;
                    bits_q <= 7'h00;
                    st_q <= ST_RXBIT; // [R7]
                end else if (tick) begin
                    tmr_q <= tmo_rl;
                    bits_q <= bits_q + 7'h01;
                    if (bits_q >= `GAP_BITS - 7'h01) begin
                        st_q <= ST_IDLE; // [R11]
                    end
                end
            end
            ST_RECOV: begin
                // Any low level restarts the idle count
                if (!lvl_q) begin
                    bits_q <= 7'h00;
                    tmr_q <= tmo_rl;
                end else if (tick) begin
                    tmr_q <= tmo_rl;
                    bits_q <= bits_q + 7'h01;
                    if (bits_q == `RECOVER_BITS - 7'h01) begin
                        st_q <= ST_IDLE; // [R13] [R14]
                    end
                end
            end
            ST_RDLY: begin
                if (tick) begin
                    tmr_q <= bit_rl;
                    bits_q <= bits_q + 7'h01;
                    if (bits_q == dly_bits - 7'h01) begin
                        rep_q <= {`SYNC_TX_BYTE, `REPLY_ADDR, 1'b0, O_RD_ADDR_Q,
                            I_RD_DATA}; // [R23] [R1]
                        crc_q <= `CRC_INIT;
                        bytes_q <= 4'h0;
                        st_q <= ST_TXB; // [R22]
                    end
                end
            end
            ST_TXB: begin
                // Seven payload bytes then the running CRC
                if (tx_ready && !tx_go_q) begin
                    if (bytes_q == 4'h8) begin
                        bits_q <= 7'h00;
                        tmr_q <= bit_rl;
                        st_q <= ST_RELS;
                    end else begin
                        tx_go_q <= 1'b1;
                        bytes_q <= bytes_q + 4'h1;
                        if (bytes_q == 4'h7) begin
                            tx_byte_q <= crc_q; // [R20]
                        end else begin
                            tx_byte_q <= rep_q[55:48]; // [R4]
                            crc_q <= crc8_byte(crc_q, rep_q[55:48]);
                            rep_q <= {rep_q[47:0], 8'h00};
                        end
                    end
                end
            end
            ST_RELS: begin
                // Hold the line high before letting go of it
                if (tick) begin
                    tmr_q <= bit_rl;
                    bits_q <= bits_q + 7'h01;
                    if (bits_q == `RELEASE_BITS - 7'h01) begin
                        st_q <= ST_IDLE; // [R23]
                    end
                end
            end
            default: begin
                st_q <= ST_IDLE;
            end
        endcase
    end
end

// ==========================================================
// Reply serialiser
swuart_tx u_tx (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_bit_len(bit_q),
    .i_go(tx_go_q),
    .i_byte(tx_byte_q),
    .o_ready(tx_ready),
    .o_txd_q(tx_line)
);

// Drive only while replying; the line is high when released
assign O_DATA_OE = (st_q == ST_TXB) | (st_q == ST_RELS); // [R23]
assign O_DATA_PIN = tx_line;

// ==========================================================
// Dual-use pin: a low pin means automatic standstill power down,
// unless software has switched that meaning off
always @(posedge I_CLK) begin
    if (!I_RST_N) begin
        O_PDN_REQ_Q <= 1'b0;
    end else begin
        O_PDN_REQ_Q <= ~I_PDN_DISABLE & ~lvl_q; // [R19]
    end
end

endmodule
`default_nettype wire

// ---- verification/swuart_slave_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Port checks of the single-wire register slave
module swuart_slave_assertions (
    input wire logic I_CLK, // Core clock
    input wire logic I_RST_N, // Sync reset, active low
    input wire logic O_DATA_PIN, // Pin output level
    input wire logic O_DATA_OE, // Pin drive enable
    input wire logic I_PDN_DISABLE, // Power-down pin disable
    input wire logic O_WR_STB_Q, // Write strobe
    input wire logic [6:0] O_WR_ADDR_Q, // Write address
    input wire logic [31:0] O_WR_DATA_Q, // Write data
    input wire logic O_RD_STB_Q, // Read strobe
    input wire logic [7:0] O_WR_COUNT_Q, // Accepted write counter
    input wire logic O_PDN_REQ_Q // Power-down request
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    // Counter moves exactly with a write strobe, by one, wrapping
    chk_count_step: assert property (
        (O_WR_STB_Q || O_WR_COUNT_Q != $past(O_WR_COUNT_Q)) |->
        (O_WR_STB_Q && O_WR_COUNT_Q == $past(O_WR_COUNT_Q) + 8'h01))
        else $error("write counter step wrong");
    chk_read_count: assert property (
        O_RD_STB_Q |-> $stable(O_WR_COUNT_Q))
        else $error("read changed write counter");
    // Write address and data only change on an accepted write
    chk_wr_fields: assert property (
        !O_WR_STB_Q |-> $stable(O_WR_ADDR_Q) && $stable(O_WR_DATA_Q))
        else $error("write fields changed without strobe");
    chk_wr_pulse: assert property (
        O_WR_STB_Q |=> !O_WR_STB_Q)
        else $error("write strobe longer than one cycle");
    chk_rd_pulse: assert property (
        O_RD_STB_Q |=> !O_RD_STB_Q)
        else $error("read strobe longer than one cycle");
    chk_strobes_apart: assert property (
        !(O_WR_STB_Q && O_RD_STB_Q))
        else $error("read and write strobe together");
    chk_idle_high: assert property (
        !O_DATA_OE |-> O_DATA_PIN)
        else $error("pin output low while not driving");
    // Reply never starts right after the request; checked over the eight cycles after the read strobe
    chk_reply_wait: assert property (
        O_RD_STB_Q |=> !O_DATA_OE [*8])
        else $error("reply started too early");
    // Driver is released only after a stretch of high stop level
    chk_release_late: assert property (
        $fell(O_DATA_OE) |-> $past(O_DATA_PIN) && $past(O_DATA_PIN, 8))
        else $error("driver released during a bit");
    chk_pdn_gate: assert property (
        I_PDN_DISABLE |=> !O_PDN_REQ_Q)
        else $error("power-down request while pin meaning disabled");

    cov_write: cover property (O_WR_STB_Q);
    cov_read: cover property (O_RD_STB_Q);
    cov_reply: cover property ($rose(O_DATA_OE));
endmodule

bind swuart_slave swuart_slave_assertions chk (
    .I_CLK(I_CLK),
    .I_RST_N(I_RST_N),
    .O_DATA_PIN(O_DATA_PIN),
    .O_DATA_OE(O_DATA_OE),
    .I_PDN_DISABLE(I_PDN_DISABLE),
    .O_WR_STB_Q(O_WR_STB_Q),
    .O_WR_ADDR_Q(O_WR_ADDR_Q),
    .O_WR_DATA_Q(O_WR_DATA_Q),
    .O_RD_STB_Q(O_RD_STB_Q),
    .O_WR_COUNT_Q(O_WR_COUNT_Q),
    .O_PDN_REQ_Q(O_PDN_REQ_Q)
);

`default_nettype wire

// ---- verification/host_uart_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Host UART on the shared single-wire line
module host_uart_model (
    input wire logic clk, // Core clock
    input wire logic line, // Resolved wire level
    output logic txd // Host drive level
);
    int bit_cyc = 20; // Bit period in cycles, above the floor of 16

    // Line rests high between frames
    initial txd = 1'b1;

    // CRC8 x^8+x^2+x+1, zero start, LSB of each byte first
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i])
            for (int j = 0; j < 8; j++)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][j]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Start low, data LSB first, stop high
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            txd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (bit_cyc) @(negedge clk);
        end
    endtask

    // Frame with CRC appended; flip corrupts the CRC on purpose
    task automatic send_frame(input logic [7:0] q[$], input logic [7:0] flip);
        q.push_back(crc8(q) ^ flip);
        foreach (q[i])
            send_byte(q[i]);
    endtask

    // Idle gap in bit times, needed after a glitch, framing or CRC error
    task automatic idle_bits(input int n);
        repeat (n * bit_cyc) @(negedge clk);
    endtask

    // Short low pulse on an idle line
    task automatic pulse(input int n);
        txd = 1'b0;
        repeat (n) @(negedge clk);
        txd = 1'b1;
    endtask

    // Receive one byte; unknown if no start comes in time or the stop is low
    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        b = 'x;
        while (line !== 1'b0 && n < 40 * bit_cyc) begin
            @(negedge clk);
            n++;
        end
        if (n < 40 * bit_cyc) begin
            repeat (bit_cyc / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(negedge clk);
                b[i] = line;
            end
            repeat (bit_cyc) @(negedge clk);
            if (line !== 1'b1)
                b = 'x;
        end
    endtask
endmodule

`default_nettype wire

// ---- verification/single_wire_uart_register_slave_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Bench for the single-wire register slave
module single_wire_uart_register_slave_tb;
    logic I_CLK;
    logic I_RST_N;
    logic I_PDN_DISABLE;
    logic [3:0] I_REPLY_DELAY;
    logic [31:0] I_RD_DATA;
    wire O_DATA_PIN;
    wire O_DATA_OE;
    wire O_WR_STB_Q;
    wire [6:0] O_WR_ADDR_Q;
    wire [31:0] O_WR_DATA_Q;
    wire O_RD_STB_Q;
    wire [6:0] O_RD_ADDR_Q;
    wire [7:0] O_WR_COUNT_Q;
    wire O_PDN_REQ_Q;
    wire host_txd;
    wire line;
    int err_count, samples_checked, wr_seen, rd_seen, t_rd, t_oe, cyc;

    // Device drive wins while enabled, otherwise the host level
    assign line = O_DATA_OE ? O_DATA_PIN : host_txd;

    swuart_slave dut (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .I_DATA_PIN(line),
        .O_DATA_PIN(O_DATA_PIN),
        .O_DATA_OE(O_DATA_OE),
        .I_PDN_DISABLE(I_PDN_DISABLE),
        .I_REPLY_DELAY(I_REPLY_DELAY),
        .I_RD_DATA(I_RD_DATA),
        .O_WR_STB_Q(O_WR_STB_Q),
        .O_WR_ADDR_Q(O_WR_ADDR_Q),
        .O_WR_DATA_Q(O_WR_DATA_Q),
        .O_RD_STB_Q(O_RD_STB_Q),
        .O_RD_ADDR_Q(O_RD_ADDR_Q),
        .O_WR_COUNT_Q(O_WR_COUNT_Q),
        .O_PDN_REQ_Q(O_PDN_REQ_Q)
    );

    host_uart_model host (
        .clk(I_CLK),
        .line(line),
        .txd(host_txd)
    );

    initial begin
        I_CLK = 1'b0;
        forever #5 I_CLK = ~I_CLK;
    end

    // Strobe counts and reply start time
    always @(posedge I_CLK) begin
        cyc++;
        if (O_WR_STB_Q === 1'b1)
            wr_seen++;
        if (O_RD_STB_Q === 1'b1) begin
            rd_seen++;
            t_rd = cyc;
        end
        if (O_DATA_OE === 1'b1 && t_oe <= t_rd)
            t_oe = cyc;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write frame; upper sync nibble set to show it is ignored yet in the CRC
    task automatic wr(input logic [7:0] node, input logic [6:0] a, input logic [31:0] d,
                      input logic [7:0] flip);
        logic [7:0] ra;
        ra = {1'b1, a};
        host.send_frame({8'ha5, node, ra, d[31:24], d[23:16], d[15:8], d[7:0]}, flip);
        host.idle_bits(2);
    endtask

    task automatic test_write();
        int w;
        logic [7:0] c;
        w = wr_seen;
        c = O_WR_COUNT_Q;
        wr(8'h00, 7'h12, 32'ha1b2c3d4, 8'h00);
        chk("write strobes", 1, wr_seen - w);
        chk("write address", 32'h12, O_WR_ADDR_Q);
        chk("write data", 32'ha1b2c3d4, O_WR_DATA_Q);
        chk("write count", 8'(c + 8'h01), O_WR_COUNT_Q);
        $display("test_write done");
    endtask

    task automatic test_glitch();
        int w;
        I_PDN_DISABLE = 1'b0;
        host.pulse(12);
        chk("power-down request", 1, O_PDN_REQ_Q);
        I_PDN_DISABLE = 1'b1;
        w = wr_seen;
        host.idle_bits(2);
        wr(8'h00, 7'h21, 32'h00000001, 8'h00);
        chk("writes after glitch", 0, wr_seen - w);
        host.idle_bits(14);
        $display("test_glitch done");
    endtask

    task automatic test_bad_crc();
        int w;
        logic [7:0] c;
        w = wr_seen;
        c = O_WR_COUNT_Q;
        wr(8'h00, 7'h33, 32'h5555aaaa, 8'h01);
        chk("bad crc strobes", 0, wr_seen - w);
        chk("bad crc count", c, O_WR_COUNT_Q);
        host.idle_bits(14);
        wr(8'h00, 7'h7f, 32'hffff0000, 8'h00);
        chk("recovered strobes", 1, wr_seen - w);
        chk("recovered data", 32'hffff0000, O_WR_DATA_Q);
        $display("test_bad_crc done");
    endtask

    task automatic test_node();
        int w;
        w = wr_seen;
        wr(8'h01, 7'h44, 32'h12345678, 8'h00);
        chk("foreign node strobes", 0, wr_seen - w);
        chk("foreign node address", 32'h7f, O_WR_ADDR_Q);
        // Cut datagram, then a long pause; next one at the fastest baud
        host.send_byte(8'h05);
        host.send_byte(8'h00);
        host.idle_bits(70);
        host.bit_cyc = 16;
        wr(8'h00, 7'h44, 32'h12345678, 8'h00);
        chk("strobes after gap", 1, wr_seen - w);
        chk("fast baud data", 32'h12345678, O_WR_DATA_Q);
        host.bit_cyc = 20;
        $display("test_node done");
    endtask

    task automatic test_read();
        logic [7:0] q[$];
        logic [7:0] b;
        logic [7:0] c;
        int r;
        r = rd_seen;
        c = O_WR_COUNT_Q;
        I_REPLY_DELAY = 4'h2;
        I_RD_DATA = 32'h8899aabb;
        host.send_frame({8'h05, 8'h00, 8'h05}, 8'h00);
        q = {8'h05, 8'hff, 8'h05, 8'h88, 8'h99, 8'haa, 8'hbb};
        q.push_back(host.crc8(q));
        foreach (q[i]) begin
            host.get_byte(b);
            chk("reply byte", q[i], b);
        end
        chk("drive held", 1, O_DATA_OE);
        chk("read strobes", 1, rd_seen - r);
        chk("read address", 32'h05, O_RD_ADDR_Q);
        chk("count after read", c, O_WR_COUNT_Q);
        chk("reply delay", 1, (t_oe - t_rd) inside {[316:328]});
        host.idle_bits(5);
        chk("drive released", 0, O_DATA_OE);
        $display("test_read done");
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence; inputs move on falling edges only
    initial begin
        I_RST_N = 1'b0;
        I_PDN_DISABLE = 1'b1;
        I_REPLY_DELAY = 4'h1;
        I_RD_DATA = 32'h0;
        repeat (10) @(negedge I_CLK);
        I_RST_N = 1'b1;
        host.idle_bits(1);
        test_write();
        test_glitch();
        test_bad_crc();
        test_node();
        test_read();
        results();
    end

    // Tests need about 15000 cycles; far beyond that means a hang
    initial begin
        repeat (40000) @(posedge I_CLK);
        err_count++;
        results();
    end
endmodule

`default_nettype wire
